// ### src/asfb_checksum.sv
// Running payload sum with the frame checksum it implies
`default_nettype none
module asfb_checksum (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Accumulate control
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] byteIn,
	// Checksum including the byte being added now
	output logic [7:0] chkNext
);
	typedef struct packed {
		logic [7:0] sum;
	} asfb_sum_t;

	asfb_sum_t cur_ff;
	asfb_sum_t nxt_cur;
	logic [7:0] addend;

	// Only the low byte of the sum matters, so it wraps freely
	always_comb begin
		nxt_cur = cur_ff;
		addend = add ? byteIn : 8'h00;
		if (clear) begin
			nxt_cur.sum = 8'h00;
		end else begin
			nxt_cur.sum = cur_ff.sum + addend;
		end
	end

	// Sum register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign chkNext = asfb_pkg::CHK_BASE - (cur_ff.sum + addend);
endmodule
`default_nettype wire

// ### src/asfb_frame_builder.sv
// Status frame builder: module status and transmit status frames onto a byte stream
`default_nettype none
module asfb_frame_builder (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Module events, one-cycle pulses
	input wire logic evWdtReset,
	input wire logic evAssoc,
	input wire logic evAssocAlt,
	input wire logic evDisassoc,
	input wire logic evNetWake,
	input wire logic evNetSleep,
	input wire logic evOverVolt,
	// Transmit completion report
	input wire logic txDone,
	input wire logic [7:0] txFrameId,
	input wire logic [15:0] txDelivAddr,
	input wire logic [7:0] txRetries,
	input wire asfb_pkg::asfb_cause_t txCause,
	input wire logic txBroadcast,
	input wire logic txRouteDisc,
	output logic txReady,
	// Overrun flag and its clear
	input wire logic ovrClear,
	output logic txOverrun,
	// Byte stream toward the serial port
	output logic [7:0] outData,
	output logic outValid,
	input wire logic outReady,
	output logic busy
);
	localparam int NB = asfb_pkg::FRAME_BYTES;
	localparam int NE = asfb_pkg::EV_COUNT;

	typedef struct packed {
		asfb_pkg::asfb_state_t state;
		logic [3:0] idx;
		logic [3:0] lastIdx;
		logic [NB-1:0][7:0] frm;
		logic [7:0] outData;
		logic outValid;
		logic [NE-1:0] evPend;
		logic txPend;
		logic [7:0] txId;
		logic [15:0] txAddr;
		logic [7:0] txRetry;
		logic [7:0] txDeliv;
		logic [7:0] txDisc;
		logic txReady;
		logic txOverrun;
		logic busy;
	} asfb_core_t;

	asfb_core_t cur_ff;
	asfb_core_t nxt_cur;

	// Encoder and checksum links
	logic [7:0] encDeliv;
	logic [15:0] encAddr;
	logic [7:0] encDisc;
	logic chkClear;
	logic chkAdd;
	logic [7:0] chkNext;

	// Event inputs gathered in pending-bit order
	logic [NE-1:0] evIn;
	logic accept;
	logic txTake;

	assign evIn = {evOverVolt, evNetSleep, evNetWake, evDisassoc, evAssocAlt, evAssoc, evWdtReset, 1'b0};
	assign accept = cur_ff.outValid && outReady;
	assign txTake = txDone && cur_ff.txReady;

	// Transmit outcome encoding at capture time
	asfb_tx_encode u_enc (
		.cause(txCause),
		.broadcast(txBroadcast),
		.routeDisc(txRouteDisc),
		.addrIn(txDelivAddr),
		.deliv(encDeliv),
		.addrOut(encAddr),
		.disc(encDisc)
	);

	// Payload sum from type byte up to the byte before the checksum
	asfb_checksum u_chk (
		.core_clk(core_clk),
		.rst(rst),
		.clear(chkClear),
		.add(chkAdd),
		.byteIn(cur_ff.outData),
		.chkNext(chkNext)
	);

	assign chkAdd = accept && (cur_ff.idx >= asfb_pkg::OFS_TYPE) && (cur_ff.idx != cur_ff.lastIdx);

	// Next-state logic for the whole builder
	always_comb begin
		logic found;
		logic [NE-1:0] clrMask;
		logic [7:0] code;
		logic [3:0] nextIdx;
		found = 1'b0;
		clrMask = '0;
		code = 8'h00;
		nextIdx = 4'h0;
		nxt_cur = cur_ff;
		chkClear = 1'b0;

		// Pick the lowest pending module event
		for (int i = 0; i < NE; i++) begin
			if (!found && cur_ff.evPend[i]) begin
				found = 1'b1;
				code = asfb_pkg::MS_CODES[i];
				clrMask = NE'(1) << i;
			end
		end

		// Transmit capture; one report is held until its frame is loaded
		if (txTake) begin
			nxt_cur.txPend = 1'b1;
			nxt_cur.txReady = 1'b0;
			nxt_cur.txId = txFrameId;
			nxt_cur.txAddr = encAddr;
			nxt_cur.txRetry = txRetries;
			nxt_cur.txDeliv = encDeliv;
			nxt_cur.txDisc = encDisc;
		end

		case (cur_ff.state)
			asfb_pkg::ST_IDLE: begin
				if (found) begin
					// Module status frame
					nxt_cur.frm = '0;
					nxt_cur.frm[asfb_pkg::OFS_START] = asfb_pkg::START_DELIM;
					nxt_cur.frm[asfb_pkg::OFS_LEN_HI] = asfb_pkg::LEN_MODEM[15:8];
					nxt_cur.frm[asfb_pkg::OFS_LEN_LO] = asfb_pkg::LEN_MODEM[7:0];
					nxt_cur.frm[asfb_pkg::OFS_TYPE] = asfb_pkg::TYPE_MODEM;
					nxt_cur.frm[asfb_pkg::OFS_STATUS] = code;
					nxt_cur.lastIdx = asfb_pkg::LAST_MODEM;
					nxt_cur.evPend = cur_ff.evPend & ~clrMask;
				end else if (cur_ff.txPend) begin
					// Transmit status frame
					nxt_cur.frm = '0;
					nxt_cur.frm[asfb_pkg::OFS_START] = asfb_pkg::START_DELIM;
					nxt_cur.frm[asfb_pkg::OFS_LEN_HI] = asfb_pkg::LEN_TXSTAT[15:8];
					nxt_cur.frm[asfb_pkg::OFS_LEN_LO] = asfb_pkg::LEN_TXSTAT[7:0];
					nxt_cur.frm[asfb_pkg::OFS_TYPE] = asfb_pkg::TYPE_TXSTAT;
					nxt_cur.frm[asfb_pkg::OFS_FRAME_ID] = cur_ff.txId;
					nxt_cur.frm[asfb_pkg::OFS_ADDR_HI] = cur_ff.txAddr[15:8];
					nxt_cur.frm[asfb_pkg::OFS_ADDR_LO] = cur_ff.txAddr[7:0];
					nxt_cur.frm[asfb_pkg::OFS_RETRY] = cur_ff.txRetry;
					nxt_cur.frm[asfb_pkg::OFS_DELIV] = cur_ff.txDeliv;
					nxt_cur.frm[asfb_pkg::OFS_DISC] = cur_ff.txDisc;
					nxt_cur.lastIdx = asfb_pkg::LAST_TXSTAT;
					// Capture slot frees as soon as the frame is in the buffer
					nxt_cur.txPend = 1'b0;
					nxt_cur.txReady = 1'b1;
				end
				if (found || cur_ff.txPend) begin
					nxt_cur.state = asfb_pkg::ST_SEND;
					nxt_cur.idx = asfb_pkg::OFS_START;
					nxt_cur.outData = asfb_pkg::START_DELIM;
					nxt_cur.outValid = 1'b1;
					nxt_cur.busy = 1'b1;
					chkClear = 1'b1;
				end
			end
			asfb_pkg::ST_SEND: begin
				// Stream advances only on a taken byte; the sink may stall freely
				if (accept) begin
					if (cur_ff.idx == cur_ff.lastIdx) begin
						nxt_cur.state = asfb_pkg::ST_IDLE;
						nxt_cur.outValid = 1'b0;
						nxt_cur.busy = 1'b0;
					end else begin
						nextIdx = cur_ff.idx + 4'h1;
						nxt_cur.idx = nextIdx;
						if (nextIdx == cur_ff.lastIdx) begin
							nxt_cur.outData = chkNext;
						end else begin
							nxt_cur.outData = cur_ff.frm[nextIdx];
						end
					end
				end
			end
			default: begin
				nxt_cur.state = asfb_pkg::ST_IDLE;
				nxt_cur.outValid = 1'b0;
				nxt_cur.busy = 1'b0;
			end
		endcase

		// New events win over the clear of their own pending bit
		nxt_cur.evPend = nxt_cur.evPend | evIn;

		// Report lost while the slot was full; set wins over clear
		if (txDone && !cur_ff.txReady) begin
			nxt_cur.txOverrun = 1'b1;
		end else if (ovrClear) begin
			nxt_cur.txOverrun = 1'b0;
		end
	end

	// State register; reset arms the power-up hardware reset report
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.state <= asfb_pkg::ST_IDLE;
			cur_ff.evPend <= asfb_pkg::EV_RESET_PEND;
			cur_ff.txReady <= 1'b1;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Outputs straight from the state register
	assign outData = cur_ff.outData;
	assign outValid = cur_ff.outValid;
	assign busy = cur_ff.busy;
	assign txReady = cur_ff.txReady;
	assign txOverrun = cur_ff.txOverrun;
endmodule
`default_nettype wire

// ### src/asfb_pkg.sv
// Constants, frame layout and status codes for the status frame builder
// Operation
// - A qualifying module event produces a frame of type 0x8A at offset 3 with a status code at offset 4.
// - The status code is 0x00 after a hardware reset and 0x01 after a watchdog reset.
// - Association reports 0x02 or 0x06, and disassociation or a failed network start reports 0x03.
// - Network wake reports 0x0B, network sleep 0x0C and input over-voltage 0x0D.
// - At power-up one module status frame goes out with the hardware-reset code and payload length 2.
// - A completed transmit request of type 0x10 or 0x11 produces a frame of type 0x8B saying how it ended.
// - Offset 4 of the transmit status frame echoes the frame identifier of the originating request.
// - Offsets 5 and 6 hold the delivery address on success and 0xFFFD on failure.
// - Offset 7 holds the number of application-level retries.
// - Delivery status at offset 8 is 0x00 success, 0x01 MAC ack failure, 0x02 collision avoidance failure.
// - Delivery status is 0x21 for a network ack failure and 0x25 for a missing route.
// - Delivery status is 0x31 for a resource shortage and 0x32 for any other internal error.
// - Delivery status is 0x74 for an oversized payload and 0x75 for an unrequested indirect message.
// - Discovery status at offset 9 is 0x00 without discovery overhead and 0x02 after a route discovery.
// - Broadcast transmissions always report delivery status 0x00, even when delivery failed.
`default_nettype none
package asfb_pkg;
	// Frame framing bytes
	localparam logic [7:0] START_DELIM = 8'h7E;
	localparam logic [7:0] CHK_BASE = 8'hFF;
	localparam logic [7:0] TYPE_MODEM = 8'h8A;
	localparam logic [7:0] TYPE_TXSTAT = 8'h8B;
	// Byte offsets within a frame
	localparam int FRAME_BYTES = 11;
	localparam logic [3:0] OFS_START = 4'h0;
	localparam logic [3:0] OFS_LEN_HI = 4'h1;
	localparam logic [3:0] OFS_LEN_LO = 4'h2;
	localparam logic [3:0] OFS_TYPE = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_FRAME_ID = 4'h4;
	localparam logic [3:0] OFS_ADDR_HI = 4'h5;
	localparam logic [3:0] OFS_ADDR_LO = 4'h6;
	localparam logic [3:0] OFS_RETRY = 4'h7;
	localparam logic [3:0] OFS_DELIV = 4'h8;
	localparam logic [3:0] OFS_DISC = 4'h9;
	// Payload lengths and checksum positions
	localparam logic [15:0] LEN_MODEM = 16'h0002;
	localparam logic [15:0] LEN_TXSTAT = 16'h0007;
	localparam logic [3:0] LAST_MODEM = 4'h5;
	localparam logic [3:0] LAST_TXSTAT = 4'hA;
	// Module events, bit index into the pending vector, lowest wins
	localparam int EV_COUNT = 8;
	localparam int EV_HW_RESET = 0;
	localparam logic [EV_COUNT-1:0] EV_RESET_PEND = 8'h01;
	// Module status codes, indexed by event bit
	localparam logic [EV_COUNT-1:0][7:0] MS_CODES = {8'h0D, 8'h0C, 8'h0B, 8'h03, 8'h06, 8'h02, 8'h01, 8'h00};
	// Transmit delivery codes
	localparam logic [7:0] DS_SUCCESS = 8'h00;
	localparam logic [7:0] DS_MAC_ACK = 8'h01;
	localparam logic [7:0] DS_CCA = 8'h02;
	localparam logic [7:0] DS_NET_ACK = 8'h21;
	localparam logic [7:0] DS_NO_ROUTE = 8'h25;
	localparam logic [7:0] DS_RESOURCE = 8'h31;
	localparam logic [7:0] DS_INTERNAL = 8'h32;
	localparam logic [7:0] DS_TOO_LARGE = 8'h74;
	localparam logic [7:0] DS_INDIRECT = 8'h75;
	localparam logic [7:0] DISC_NONE = 8'h00;
	localparam logic [7:0] DISC_ROUTE = 8'h02;
	localparam logic [15:0] ADDR_UNKNOWN = 16'hFFFD;
	// Transmit outcome as reported by the radio side
	typedef enum logic [3:0] {
		CAUSE_OK,
		CAUSE_MAC_ACK,
		CAUSE_CCA,
		CAUSE_NET_ACK,
		CAUSE_NO_ROUTE,
		CAUSE_RESOURCE,
		CAUSE_INTERNAL,
		CAUSE_TOO_LARGE,
		CAUSE_INDIRECT
	} asfb_cause_t;
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SEND
	} asfb_state_t;
endpackage
`default_nettype wire

// ### src/asfb_tx_encode.sv
// Maps a transmit outcome to delivery status, address and discovery bytes
`default_nettype none
module asfb_tx_encode (
	// Outcome from the radio side
	input wire asfb_pkg::asfb_cause_t cause,
	input wire logic broadcast,
	input wire logic routeDisc,
	input wire logic [15:0] addrIn,
	// Encoded frame fields
	output logic [7:0] deliv,
	output logic [15:0] addrOut,
	output logic [7:0] disc
);
	logic [7:0] rawCode;

	// Outcome to code; unknown outcomes fall into the internal error bucket
	always_comb begin
		case (cause)
			asfb_pkg::CAUSE_OK: rawCode = asfb_pkg::DS_SUCCESS;
			asfb_pkg::CAUSE_MAC_ACK: rawCode = asfb_pkg::DS_MAC_ACK;
			asfb_pkg::CAUSE_CCA: rawCode = asfb_pkg::DS_CCA;
			asfb_pkg::CAUSE_NET_ACK: rawCode = asfb_pkg::DS_NET_ACK;
			asfb_pkg::CAUSE_NO_ROUTE: rawCode = asfb_pkg::DS_NO_ROUTE;
			asfb_pkg::CAUSE_RESOURCE: rawCode = asfb_pkg::DS_RESOURCE;
			asfb_pkg::CAUSE_TOO_LARGE: rawCode = asfb_pkg::DS_TOO_LARGE;
			asfb_pkg::CAUSE_INDIRECT: rawCode = asfb_pkg::DS_INDIRECT;
			default: rawCode = asfb_pkg::DS_INTERNAL;
		endcase
	end

	// Broadcasts carry no ack, so they always claim success
	assign deliv = broadcast ? asfb_pkg::DS_SUCCESS : rawCode;
	assign addrOut = (deliv == asfb_pkg::DS_SUCCESS) ? addrIn : asfb_pkg::ADDR_UNKNOWN;
	assign disc = routeDisc ? asfb_pkg::DISC_ROUTE : asfb_pkg::DISC_NONE;
endmodule
`default_nettype wire

// ### verif/asfb_frame_asserts.sv
// Checker for the status frame builder byte stream and report slot
`default_nettype none
module asfb_frame_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Report slot
	input wire logic txDone,
	input wire logic txReady,
	input wire logic txOverrun,
	// Byte stream
	input wire logic [7:0] outData,
	input wire logic outValid,
	input wire logic outReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] idx_ff;
	logic [7:0] len_ff;
	logic [7:0] sum_ff;
	logic [7:0] lastPos;
	assign lastPos = len_ff + 8'h03;
	// Position and payload sum; outValid drops between frames, which restarts them
	always_ff @(posedge core_clk) begin
		if (rst || !outValid) begin
			idx_ff <= 4'h0;
			sum_ff <= 8'h00;
		end else if (outReady) begin
			idx_ff <= idx_ff + 4'h1;
			sum_ff <= (idx_ff > 4'h2) ? sum_ff + outData : 8'h00;
		end
	end
	// Length low byte, kept so the checksum position is known
	always_ff @(posedge core_clk) begin
		if (rst) begin
			len_ff <= 8'h00;
		end else if (outValid && outReady && idx_ff == 4'h2) begin
			len_ff <= outData;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_start_byte: assert property (outValid && idx_ff == 4'h0 |-> outData == 8'h7E)
		else $error("frame does not open with start byte");
	chk_len_high: assert property (outValid && idx_ff == 4'h1 |-> outData == 8'h00)
		else $error("length high byte wrong");
	chk_len_low: assert property (outValid && idx_ff == 4'h2 |-> outData inside {8'h02, 8'h07})
		else $error("length low byte wrong");
	chk_frame_type: assert property (outValid && idx_ff == 4'h3 |-> outData == (len_ff == 8'h02 ? 8'h8A : 8'h8B))
		else $error("type byte does not match length");
	chk_modem_code: assert property (outValid && idx_ff == 4'h4 && len_ff == 8'h02 |->
		outData inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h0B, 8'h0C, 8'h0D})
		else $error("module status code out of set");
	chk_deliv_code: assert property (outValid && idx_ff == 4'h8 |->
		outData inside {8'h00, 8'h01, 8'h02, 8'h21, 8'h25, 8'h31, 8'h32, 8'h74, 8'h75})
		else $error("delivery code out of set");
	chk_check_byte: assert property (outValid && {4'h0, idx_ff} == lastPos |-> outData == 8'hFF - sum_ff)
		else $error("checksum byte wrong");
	chk_stall_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
		else $error("byte changed while stalled");
	chk_slot_taken: assert property (txDone && txReady |=> !txReady)
		else $error("report slot not closed after capture");
	chk_overrun_set: assert property (txDone && !txReady |=> txOverrun)
		else $error("dropped report not flagged");
	cover property (outValid && idx_ff == 4'h3 && outData == 8'h8B);
	cover property (outValid && !outReady);
	cover property (txDone && !txReady);
endmodule
bind asfb_frame_builder asfb_frame_chk u_frame_chk (.core_clk(core_clk), .rst(rst), .txDone(txDone), .txReady(txReady),
	.txOverrun(txOverrun), .outData(outData), .outValid(outValid), .outReady(outReady));
`default_nettype wire

// ### verif/asfb_host_sink.sv
// Host model: takes the byte stream with random stalls and finds frame ends
`default_nettype none
module asfb_host_sink (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Stream from the builder
	input wire logic [7:0] outData,
	input wire logic outValid,
	output logic outReady,
	// Stall control and observed bytes
	input wire logic stall,
	output logic [7:0] rxByte,
	output logic rxStrobe,
	output logic frameEnd
);
	timeunit 1ns;
	timeprecision 1ps;
	int pos;
	int len;
	// Frame end from the parsed length, not from the type, so a bad type cannot hide it
	always @(posedge core_clk) begin
		rxStrobe <= outValid && outReady && !rst;
		rxByte <= outData;
		frameEnd <= 1'b0;
		if (rst) begin
			pos = 0;
		end else if (outValid && outReady) begin
			if (pos == 2) len = outData;
			if (pos > 2 && pos == len + 3) begin
				frameEnd <= 1'b1;
				pos = 0;
			end else begin
				pos++;
			end
		end
		outReady <= !stall || ($urandom % 3 != 0);
	end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the status frame builder
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst = 1, txDone = 0, txBroadcast = 0, txRouteDisc = 0, ovrClear = 0, stall = 0;
	logic [6:0] ev = 0;
	logic [7:0] txFrameId = 0, txRetries = 0, outData, rxByte;
	logic [15:0] txDelivAddr = 0;
	asfb_pkg::asfb_cause_t txCause = asfb_pkg::CAUSE_OK;
	logic txReady, txOverrun, outValid, outReady, busy, rxStrobe, frameEnd;
	logic [7:0] expQ[$];
	int errors = 0, n_tests = 0, nFrames = 0, gotFrames = 0;
	logic [7:0] codes[7] = '{8'h01, 8'h02, 8'h06, 8'h03, 8'h0B, 8'h0C, 8'h0D};
	asfb_frame_builder uut (.core_clk(core_clk), .rst(rst), .evWdtReset(ev[0]), .evAssoc(ev[1]),
		.evAssocAlt(ev[2]), .evDisassoc(ev[3]), .evNetWake(ev[4]), .evNetSleep(ev[5]), .evOverVolt(ev[6]),
		.txDone(txDone), .txFrameId(txFrameId), .txDelivAddr(txDelivAddr), .txRetries(txRetries),
		.txCause(txCause), .txBroadcast(txBroadcast), .txRouteDisc(txRouteDisc), .txReady(txReady),
		.ovrClear(ovrClear), .txOverrun(txOverrun), .outData(outData), .outValid(outValid),
		.outReady(outReady), .busy(busy));
	asfb_host_sink host (.core_clk(core_clk), .rst(rst), .outData(outData), .outValid(outValid),
		.outReady(outReady), .stall(stall), .rxByte(rxByte), .rxStrobe(rxStrobe), .frameEnd(frameEnd));
	initial forever #2.5 core_clk = ~core_clk;
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	// Expected frame: start, length, payload, checksum
	function automatic void push_frame(input logic [7:0] pl[$]);
		logic [7:0] s = 8'h00;
		expQ.push_back(8'h7E);
		expQ.push_back(8'h00);
		expQ.push_back(8'(pl.size()));
		foreach (pl[i]) begin
			expQ.push_back(pl[i]);
			s += pl[i];
		end
		expQ.push_back(8'hFF - s);
		nFrames++;
	endfunction
	// Broadcast hides failures behind success
	function automatic logic [7:0] dcode(input logic [3:0] c, input logic bc);
		logic [7:0] t[9] = '{8'h00, 8'h01, 8'h02, 8'h21, 8'h25, 8'h31, 8'h32, 8'h74, 8'h75};
		return bc ? 8'h00 : (c < 4'h9 ? t[c] : 8'h32);
	endfunction
	// Each accepted byte must be the next expected one
	always @(posedge core_clk) begin
		if (rxStrobe) check("byte", expQ.size() != 0 ? {8'h00, expQ.pop_front()} : 16'hFFFF, {8'h00, rxByte});
		if (frameEnd) gotFrames++;
	end
	task automatic send_tx(input logic [3:0] c, input logic bc, input int hold, input logic [6:0] e);
		logic [7:0] id, rt, d;
		logic [15:0] a;
		logic rd;
		id = 8'($urandom);
		a = 16'($urandom);
		rt = 8'($urandom);
		rd = 1'($urandom);
		d = dcode(c, bc);
		push_frame({8'h8B, id, d != 0 ? 8'hFF : a[15:8], d != 0 ? 8'hFD : a[7:0], rt, d, rd ? 8'h02 : 8'h00});
		@(posedge core_clk);
		while (txReady !== 1'b1) @(posedge core_clk);
		txDone <= 1'b1;
		txFrameId <= id;
		txDelivAddr <= a;
		txRetries <= rt;
		txCause <= asfb_pkg::asfb_cause_t'(c);
		txBroadcast <= bc;
		txRouteDisc <= rd;
		ev <= e;
		repeat (hold) @(posedge core_clk);
		txDone <= 1'b0;
		ev <= 7'h00;
	endtask
	task automatic wait_idle();
		int n;
		for (n = 0; n < 3000 && (expQ.size() != 0 || busy !== 1'b0); n++)
			@(posedge core_clk);
		check("drain", 16'h0000, 16'(expQ.size()));
		check("busy", 16'h0000, {15'h0, busy});
	endtask
	task automatic complete_run();
		if (errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Run needs well under 10000 cycles even with stalls
	initial begin
		#200us;
		errors++;
		complete_run();
	end
	initial begin
		void'($urandom(3488));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		push_frame({8'h8A, 8'h00});
		wait_idle();
		// Events one by one, then all together so the lowest code leads
		for (int i = 0; i < 7; i++) begin
			push_frame({8'h8A, codes[i]});
			@(posedge core_clk);
			ev <= 7'(1 << i);
			@(posedge core_clk);
			ev <= 7'h00;
			wait_idle();
		end
		foreach (codes[i]) push_frame({8'h8A, codes[i]});
		ev <= 7'h7F;
		@(posedge core_clk);
		ev <= 7'h00;
		wait_idle();
		// Back-to-back reports over every cause, stalls and broadcast
		for (int k = 0; k < 40; k++) begin
			stall <= k[1];
			send_tx(4'(k % 10), k >= 30, 1, 7'h00);
		end
		wait_idle();
		// Event and report on one edge: module frame first
		push_frame({8'h8A, 8'h0D});
		send_tx(4'h3, 1'b0, 1, 7'h40);
		wait_idle();
		// Second report while the slot is taken is dropped and flagged
		stall <= 1'b1;
		send_tx(4'h5, 1'b0, 2, 7'h00);
		repeat (2) @(posedge core_clk);
		check("overrun set", 16'h0001, {15'h0, txOverrun});
		ovrClear <= 1'b1;
		@(posedge core_clk);
		ovrClear <= 1'b0;
		@(posedge core_clk);
		check("overrun clear", 16'h0000, {15'h0, txOverrun});
		wait_idle();
		check("frames", 16'(nFrames), 16'(gotFrames));
		complete_run();
	end
endmodule
`default_nettype wire
